/* rtl/srsf_status.sv */
// Purpose: Sample-ready status register at address 0x00 of a three-axis sensor.
// Assumes: Register reads arrive as one-cycle strobes with an address; clk is 20 MHz.
// Notes: Address 0x00 shows these flags only while the queue mode field is zero.
`timescale 1ns/1ns
module srsf_status #(
  parameter int AXES = 3
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Acquisition events, one-cycle pulses, and their per-axis enables, bit 0 X, 1 Y, 2 Z.
  input  wire logic [2:0] sample_done,
  input  wire logic [2:0] axis_enable,
  // Host register access.
  input  wire logic       reg_read,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  // High-byte read strobes, one-cycle pulses, bit 0 X, 1 Y, 2 Z.
  input  wire logic [2:0] high_read,
  // Queue subsystem.
  input  wire logic [1:0] queue_mode,
  input  wire logic [7:0] queue_status,
  // Read data.
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  output logic [7:0]      sample_ready_status
);
  srsf_axis_if axis_bus ();
  srsf_pkg::srsf_view_type view;
  logic [2:0] set_read_pending;
  logic       all_ready;
  logic       all_overrun;
  logic       set_event;
  logic       set_overrun;
  logic       set_done;
  logic [2:0] next_pending;

  assign axis_bus.sample_done = sample_done & axis_enable;
  assign axis_bus.high_read   = high_read;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      srsf_axis_flags u_flags (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .sample_done (axis_bus.sample_done[g]),
        .high_read   (axis_bus.high_read[g]),
        .ready       (axis_bus.ready[g]),
        .overrun     (axis_bus.overrun[g])
      );
    end
  endgenerate

  // Tracks which high bytes were read since the last new sample or the last read of all three.
  assign set_event    = |axis_bus.sample_done;
  assign set_overrun  = |(axis_bus.sample_done & axis_bus.ready);
  assign next_pending = set_event ? 3'b000 : (set_read_pending | high_read);
  assign set_done     = &(set_read_pending | high_read);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      set_read_pending <= 3'b000;
    end else if (set_done && !set_event) begin
      set_read_pending <= 3'b000;
    end else begin
      set_read_pending <= next_pending;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      all_ready <= 1'b0;
    end else if (set_event) begin
      all_ready <= 1'b1;
    end else if (set_done) begin
      all_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      all_overrun <= 1'b0;
    end else if (set_overrun) begin
      all_overrun <= 1'b1;
    end else if (set_done) begin
      all_overrun <= 1'b0;
    end
  end

  // Status byte; host writes are never looked at here.
  always_comb begin
    sample_ready_status = srsf_pkg::STATUS_RESET;
    sample_ready_status[srsf_pkg::BIT_ALL_OVERRUN] = all_overrun;
    sample_ready_status[srsf_pkg::BIT_OVERRUN_BASE +: 3] = axis_bus.overrun;
    sample_ready_status[srsf_pkg::BIT_ALL_READY] = all_ready;
    sample_ready_status[srsf_pkg::BIT_READY_BASE +: 3] = axis_bus.ready;
  end

  always_comb begin
    if (!reg_read || reg_addr != srsf_pkg::STATUS_ADDR) begin
      view = srsf_pkg::SRSF_VIEW_IDLE;
    end else if (queue_mode == srsf_pkg::QUEUE_MODE_OFF) begin
      view = srsf_pkg::SRSF_VIEW_FLAGS;
    end else begin
      view = srsf_pkg::SRSF_VIEW_QUEUE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= srsf_pkg::STATUS_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= view != srsf_pkg::SRSF_VIEW_IDLE;
      case (view)
        srsf_pkg::SRSF_VIEW_FLAGS: begin
          reg_rdata <= sample_ready_status;
        end
        srsf_pkg::SRSF_VIEW_QUEUE: begin
          reg_rdata <= queue_status;
        end
        default: begin
          reg_rdata <= reg_rdata;
        end
      endcase
    end
  end

  logic unused_write;
  assign unused_write = reg_write ^ (|reg_wdata);
endmodule

/* rtl/srsf_pkg.sv */
// Purpose: Shared constants for the sample-ready status flags block.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes: Status register sits at address 0x00 of the device register space.
package srsf_pkg;
  localparam int          AXIS_COUNT       = 3;
  localparam logic [7:0]  STATUS_ADDR      = 8'h00;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [1:0]  QUEUE_MODE_OFF   = 2'h0;
  localparam int          BIT_ALL_OVERRUN  = 7;
  localparam int          BIT_OVERRUN_BASE = 4;
  localparam int          BIT_ALL_READY    = 3;
  localparam int          BIT_READY_BASE   = 0;
  localparam int          AXIS_X           = 0;
  localparam int          AXIS_Y           = 1;
  localparam int          AXIS_Z           = 2;

  typedef enum logic [2:0] {
    SRSF_VIEW_IDLE  = 3'b001,
    SRSF_VIEW_FLAGS = 3'b010,
    SRSF_VIEW_QUEUE = 3'b100
  } srsf_view_type;
endpackage

/* rtl/srsf_axis_if.sv */
// Purpose: Carries per-axis event and clear strobes plus flag state.
// Assumes: All signals in the clk domain.
// Notes: One bit per axis, index 0 is X, 1 is Y, 2 is Z.
`timescale 1ns/1ns
interface srsf_axis_if;
  logic [2:0] sample_done;
  logic [2:0] high_read;
  logic [2:0] ready;
  logic [2:0] overrun;
  modport owner (input sample_done, input high_read, output ready, output overrun);
  modport user  (output sample_done, output high_read, input ready, input overrun);
endinterface

/* rtl/srsf_axis_flags.sv */
// Purpose: Ready and overrun flags for one axis.
// Assumes: Strobes are one-cycle pulses synchronous to clk.
// Notes: A new sample in the same cycle as a clearing read keeps the flag set.
`timescale 1ns/1ns
module srsf_axis_flags (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Strobes.
  input  wire logic sample_done,
  input  wire logic high_read,
  // Flags.
  output logic      ready,
  output logic      overrun
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else if (sample_done) begin
      ready <= 1'b1;
    end else if (high_read) begin
      ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrun <= 1'b0;
    end else if (sample_done && ready) begin
      overrun <= 1'b1;
    end else if (high_read) begin
      overrun <= 1'b0;
    end
  end
endmodule

/* tb/srsf_asserts.sv */
// Purpose: Port checks of the status flags.
// Assumes: Inputs stay low in reset.
// Notes: Bound below.
`timescale 1ns/1ns
module srsf_asserts (
  // Ports watched.
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [2:0] sample_done,
  input wire logic [2:0] axis_enable,
  input wire logic [2:0] high_read,
  input wire logic       reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [1:0] queue_mode,
  input wire logic [7:0] queue_status,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [7:0] sample_ready_status
);
  logic [2:0] sd;
  logic       rd;
  logic [7:0] s;
  assign sd = sample_done & axis_enable;
  assign rd = reg_read && reg_addr == 8'h00;
  assign s  = sample_ready_status;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_valid: assert property (rd |=> reg_rvalid) else $error("rvalid");
  a_flags_view: assert property (rd && queue_mode == 2'h0 |=> reg_rdata == $past(s)) else $error("flags");
  a_queue_view: assert property (rd && queue_mode != 2'h0 |=> reg_rdata == $past(queue_status)) else $error("queue");
  a_ready_set: assert property (1 |=> (s[2:0] & $past(sd)) == $past(sd)) else $error("rdy set");
  a_ready_clear: assert property (1 |=> (s[2:0] & $past(high_read & ~sd)) == 3'h0) else $error("rdy clr");
  a_over_set: assert property (1 |=> (s[6:4] & $past(sd & s[2:0])) == $past(sd & s[2:0])) else $error("ovr");
  a_over_clear: assert property (1 |=> (s[6:4] & $past(high_read & ~(sd & s[2:0]))) == 3'h0) else $error("oc");
  a_all_ready: assert property (|sd |=> s[3]) else $error("all rdy");
  a_all_over: assert property (|(sd & s[2:0]) |=> s[7]) else $error("all ovr");
endmodule
bind srsf_status srsf_asserts srsf_asserts_i (.clk, .sys_rst, .sample_done, .axis_enable, .high_read, .reg_read,
  .reg_addr, .queue_mode, .queue_status, .reg_rdata, .reg_rvalid, .sample_ready_status);

/* tb/srsf_host_model.sv */
// Purpose: Host that reads the axis high bytes.
// Assumes: Requests arrive at the falling edge.
// Notes: Each falling edge copies the request to the strobe, for as long as it is held.
`timescale 1ns/1ns
module srsf_host_model (
  // Clock and request.
  input wire logic       clk,
  input wire logic [2:0] want,
  // Strobes.
  output logic     [2:0] high_read
);
  initial high_read = 3'h0;
  always @(negedge clk) high_read <= want;
endmodule

/* tb/sample_ready_status_flags_tb_top.sv */
// Purpose: Random and corner tests of the status flags.
// Assumes: Inputs change at the falling edge.
// Notes: A reference function gives the flags.
`timescale 1ns/1ns
module sample_ready_status_flags_tb_top;
  logic       clk = 1'b0, sys_rst = 1'b1, reg_read = 1'b0, reg_write = 1'b0, corner = 1'b0, reg_rvalid;
  logic [2:0] sample_done = 3'h0, axis_enable = 3'h7, want = 3'h0, high_read, sd, np, pend;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, queue_status = 8'h00, reg_rdata, sample_ready_status, st;
  logic [1:0] queue_mode = 2'h0;
  int         bad_count = 0, num_checks = 0, seed;
  always #25 clk = ~clk;
  srsf_status srsf_status_i (.clk, .sys_rst, .sample_done, .axis_enable, .reg_read, .reg_write, .reg_addr,
    .reg_wdata, .high_read, .queue_mode, .queue_status, .reg_rdata, .reg_rvalid, .sample_ready_status);
  srsf_host_model srsf_host_model_i (.clk, .want, .high_read);
  task automatic check(input string n, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] next_flags(input logic [7:0] f, input logic [2:0] d, h, p);
    return {|(d & f[2:0]) | (f[7] & |p), (d & f[2:0]) | (f[6:4] & ~h), |d | (f[3] & |p), d | (f[2:0] & ~h)};
  endfunction
  task automatic step();
    @(negedge clk);
    sd = sample_done & axis_enable;
    np = (|sd) ? 3'h7 : pend & ~high_read;
    check("rvalid", {7'h00, reg_rvalid}, {7'h00, reg_read && reg_addr == 8'h00});
    if (reg_read && reg_addr == 8'h00) check("rdata", reg_rdata, (queue_mode != 2'h0) ? queue_status : st);
    st = next_flags(st, sd, high_read, pend & ~high_read);
    pend = np;
    check("status", sample_ready_status, st);
    sample_done <= corner ? 3'h7 : 3'($urandom & $urandom);
    axis_enable <= ($urandom % 8 != 0) ? 3'h7 : 3'($urandom);
    want <= corner ? 3'h7 : 3'($urandom & $urandom);
    reg_read <= 1'($urandom);
    reg_write <= 1'($urandom);
    reg_addr <= ($urandom % 2 == 0) ? 8'h00 : 8'($urandom);
    reg_wdata <= 8'($urandom);
    queue_mode <= ($urandom % 4 == 0) ? 2'($urandom) : 2'h0;
    queue_status <= 8'($urandom);
  endtask
  initial begin
    seed = $urandom(32'h0000_e14f);
    st = 8'h00;
    pend = 3'h0;
    repeat (6) @(negedge clk);
    check("reset", sample_ready_status, 8'h00);
    sys_rst <= 1'b0;
    repeat (2000) step();
    $display("random test done");
    corner = 1'b1;
    repeat (20) step();
    corner = 1'b0;
    repeat (200) step();
    $display("corner test done");
    close_out();
  end
  initial begin
    #(3000 * 50);
    bad_count++;
    close_out();
  end
endmodule
